// >>> logic/bsls_pkg.sv
package bsls_pkg;

  // Receive FIFO geometry: power-of-two entry count, fixed entry size.
  localparam int unsigned ENTRY_BYTES = 48;
  localparam int unsigned ENTRY_NUM   = 8;
  localparam int unsigned PTR_W       = 3;
  localparam int unsigned MEM_DEPTH   = ENTRY_BYTES * ENTRY_NUM;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CMD       = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_CONN_INTV = 8'h0C;
  localparam logic [7:0] OFS_LEAD      = 8'h10;
  localparam logic [7:0] OFS_WIN       = 8'h14;
  localparam logic [7:0] OFS_ADV_INTV  = 8'h18;
  localparam logic [7:0] OFS_ADV_LEN   = 8'h1C;
  localparam logic [7:0] OFS_SCAN_INTV = 8'h20;
  localparam logic [7:0] OFS_RX_DATA   = 8'h24;
  localparam logic [7:0] OFS_RX_IDX    = 8'h28;
  localparam logic [7:0] OFS_RX_POP    = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h30;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h34;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h38;

  // Control bit positions.
  localparam int unsigned CTRL_ADV_EN       = 0;
  localparam int unsigned CTRL_ADV_IN_CONN  = 1;
  localparam int unsigned CTRL_SCAN_IN_ADV  = 2;
  localparam int unsigned CTRL_SCAN_IN_CONN = 3;
  // Command bit positions.
  localparam int unsigned CMD_CONNECT = 0;
  localparam int unsigned CMD_LEAVE   = 1;
  // Interrupt bit positions.
  localparam int unsigned EV_START    = 0;
  localparam int unsigned EV_POST     = 1;
  localparam int unsigned EV_OVERFLOW = 2;
  localparam int unsigned EV_RX_PKT   = 3;

  // Advertising channels used for scanning.
  localparam logic [5:0] CHAN_FIRST = 6'h25;
  localparam logic [5:0] CHAN_MID   = 6'h26;
  localparam logic [5:0] CHAN_LAST  = 6'h27;

  // Reset values of the timing registers, in clk_sys cycles.
  localparam logic [31:0] CONN_INTV_RST = 32'h0001_D4C0;
  localparam logic [31:0] LEAD_RST      = 32'h0000_0190;
  localparam logic [31:0] WIN_RST       = 32'h0000_2710;
  localparam logic [31:0] ADV_INTV_RST  = 32'h0001_86A0;
  localparam logic [31:0] ADV_LEN_RST   = 32'h0000_3A98;
  localparam logic [31:0] SCAN_INTV_RST = 32'h0000_C350;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_ADV  = 2'b01,
    LINK_CONN = 2'b10
  } bsls_link_t;

  typedef enum logic [2:0] {
    PH_SLEEP = 3'b000,
    PH_START = 3'b001,
    PH_WORK  = 3'b010,
    PH_POST  = 3'b011,
    PH_ADV   = 3'b100,
    PH_SCAN  = 3'b101
  } bsls_phase_t;

  // Packet bytes arriving from the radio receiver.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       more_data_flag;
  } bsls_rx_t;

  // Commands toward the radio.
  typedef struct packed {
    logic       rx_en;
    logic       ack_send;
    logic       ack_withhold;
    logic       adv_active;
    logic       scan_active;
    logic       sleep_allow;
    logic [5:0] channel;
  } bsls_phy_t;

  typedef struct packed {
    bsls_link_t  link;
    bsls_phase_t phase;
    logic [3:0]  ctrl;
    logic [31:0] conn_intv;
    logic [31:0] lead;
    logic [31:0] win;
    logic [31:0] adv_intv;
    logic [31:0] adv_len;
    logic [31:0] scan_intv;
    logic [31:0] ivl_cnt;
    logic [31:0] ph_cnt;
    logic [31:0] now;
    logic [31:0] last_scan;
    logic [5:0]  chan;
    logic [PTR_W:0] wptr;
    logic [PTR_W:0] rptr;
    logic [5:0]  widx;
    logic        in_pkt;
    logic        drop;
    logic [5:0]  ridx;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic        ack_send;
    logic        ack_withhold;
    logic        wb_ack;
    logic [31:0] wb_dat;
  } bsls_state_t;

  localparam bsls_state_t STATE_RST = '{
    link: LINK_IDLE, phase: PH_SLEEP, conn_intv: CONN_INTV_RST,
    lead: LEAD_RST, win: WIN_RST, adv_intv: ADV_INTV_RST,
    adv_len: ADV_LEN_RST, scan_intv: SCAN_INTV_RST, chan: CHAN_FIRST,
    default: '0};

endpackage : bsls_pkg

// >>> logic/bsls_sched.sv
`timescale 1ns/10ps

// How it works
// R01 - Each connection interval opens with a receive event.
// R02 - More data flag keeps the event receiving.
// R03 - Timer opens start phase before master sends.
// R04 - Working phase receives and acknowledges autonomously.
// R05 - Timer moves to post phase after exchange.
// R06 - Sleep allowed only in sleep phase; barred in start, work, post, adv and scan.
// R07 - Received packets are copied, write pointer advances.
// R08 - Read pointer advances only on software pop.
// R09 - Control packets executed, data packets forwarded; here both are queued, and STATUS only flags a control packet at the head.
// R10 - Entries of 48 bytes, 8 entries.
// R11 - Full FIFO withholds acknowledgement for retransmission.
// R12 - Overflow raises a notification to software.
// R13 - Advertising event follows receive event when enabled.
// R14 - Extensions enabled only in their own state.
// R15 - Scanning fills advertising interval outside adv event.
// R16 - Scanning fills connection interval outside receive event.
// R17 - Scan setup advances channel after scan interval.
// R18 - Leaving connection goes to advertising or idle.
// R19 - Pointers wrap; occupancy is their difference.
module bsls_sched (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Wishbone slave.
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output      logic [31:0]       wb_dat_o,
  output      logic              wb_ack_o,
  // Radio receiver side.
  input  wire bsls_pkg::bsls_rx_t  rx,
  output      bsls_pkg::bsls_phy_t phy,
  // Interrupt.
  output      logic              irq
);

  bsls_pkg::bsls_state_t st;
  bsls_pkg::bsls_state_t next_st;
  localparam int unsigned PTR_W_L = bsls_pkg::PTR_W;

  // Packet storage: one flat byte array indexed by entry and byte.
  logic [7:0] mem [0:bsls_pkg::MEM_DEPTH-1];

  logic [3:0]             ev;
  logic                   leave_evt;
  logic                   scan_ok;
  logic                   bus_req;
  logic [PTR_W_L:0]       occ;
  logic [31:0]            per;
  logic [31:0]            wval;
  logic [8:0]             waddr;
  logic [8:0]             raddr;
  logic [8:0]             haddr;
  logic                   wr_mem;

  // Byte address of a byte inside an entry.
  function automatic logic [8:0] ent_addr(input logic [PTR_W_L-1:0] p,
                                          input logic [5:0] i);
    ent_addr = 9'(p) * 9'(bsls_pkg::ENTRY_BYTES) + 9'(i);
  endfunction : ent_addr

  // Merge write data into a register under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = sel[b] ? dat[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////

  // Occupancy comes from the pointer difference, so wrap is free.
  assign occ     = st.wptr - st.rptr; // R19
  assign bus_req = wb_cyc_i && wb_stb_i && !st.wb_ack;
  assign waddr   = ent_addr(st.wptr[PTR_W_L-1:0], st.widx); // R10
  assign raddr   = ent_addr(st.rptr[PTR_W_L-1:0], st.ridx);
  assign haddr   = ent_addr(st.rptr[PTR_W_L-1:0], 6'h00);
  assign wval    = merge(32'h0000_0000, wb_dat_i, wb_sel_i);

  // Next state of the whole scheduler.
  always_comb begin
    next_st              = st;
    next_st.ack_send     = 1'b0;
    next_st.ack_withhold = 1'b0;
    next_st.wb_ack       = 1'b0;
    ev                   = 4'h0;
    leave_evt            = 1'b0;
    wr_mem               = 1'b0;
    next_st.now          = st.now + 32'h0000_0001;
    next_st.ph_cnt       = st.ph_cnt + 32'h0000_0001;
    per = (st.link == bsls_pkg::LINK_CONN) ? st.conn_intv : st.adv_intv;
    scan_ok = (st.link == bsls_pkg::LINK_ADV
               && st.ctrl[bsls_pkg::CTRL_SCAN_IN_ADV])
           || (st.link == bsls_pkg::LINK_CONN
               && st.ctrl[bsls_pkg::CTRL_SCAN_IN_CONN]);

    // Interval timer, restarted at every interval boundary.
    if (st.link == bsls_pkg::LINK_IDLE || st.ivl_cnt >= per - 32'h1) begin
      next_st.ivl_cnt = '0;
    end else begin
      next_st.ivl_cnt = st.ivl_cnt + 32'h0000_0001;
    end

    // Phase sequencing inside an interval.
    unique case (st.phase)
      bsls_pkg::PH_SLEEP, bsls_pkg::PH_SCAN: begin
        if (st.link == bsls_pkg::LINK_CONN
            && st.ivl_cnt == st.conn_intv - st.lead) begin
          next_st.phase = bsls_pkg::PH_START; // R01 R03
          ev[bsls_pkg::EV_START] = 1'b1; // R03
        end else if (st.link == bsls_pkg::LINK_ADV
                     && st.ivl_cnt == 32'h0) begin
          next_st.phase  = bsls_pkg::PH_ADV;
          next_st.ph_cnt = '0;
        end
      end
      bsls_pkg::PH_START: begin
        next_st.phase  = bsls_pkg::PH_WORK; // R04
        next_st.ph_cnt = '0;
      end
      bsls_pkg::PH_WORK: begin
        if (rx.valid) begin
          // First byte decides whether the packet fits.
          if (!st.in_pkt) begin
            next_st.drop = (occ == (PTR_W_L+1)'(bsls_pkg::ENTRY_NUM)); // R11
          end
          if (!(st.in_pkt ? st.drop : occ == (PTR_W_L+1)'(bsls_pkg::ENTRY_NUM))
              && st.widx < 6'(bsls_pkg::ENTRY_BYTES)) begin
            wr_mem = 1'b1; // R07
          end
          next_st.in_pkt = !rx.last;
          next_st.widx   = rx.last ? 6'h00 : st.widx + 6'h01;
          if (rx.last) begin
            if (st.in_pkt ? st.drop
                : occ == (PTR_W_L+1)'(bsls_pkg::ENTRY_NUM)) begin
              next_st.ack_withhold       = 1'b1; // R11
              ev[bsls_pkg::EV_OVERFLOW] = 1'b1; // R12
            end else begin
              next_st.wptr             = st.wptr + 1'b1; // R07 R19
              next_st.ack_send         = 1'b1; // R01 R04
              ev[bsls_pkg::EV_RX_PKT] = 1'b1;
            end
          end
        end
        // Stay while the master announces more and the window lasts; else close the event.
        if ((rx.valid && rx.last && !rx.more_data_flag)
            || st.ph_cnt >= st.win) begin
          next_st.phase  = bsls_pkg::PH_POST; // R02 R05
          next_st.in_pkt = 1'b0;
          next_st.widx   = 6'h00;
        end
      end
      bsls_pkg::PH_POST: begin
        ev[bsls_pkg::EV_POST] = 1'b1; // R05
        if (st.ctrl[bsls_pkg::CTRL_ADV_IN_CONN]) begin
          next_st.phase  = bsls_pkg::PH_ADV; // R13
          next_st.ph_cnt = '0;
        end else begin
          leave_evt = 1'b1;
        end
      end
      bsls_pkg::PH_ADV: begin
        if (st.ph_cnt >= st.adv_len - 32'h1) begin
          leave_evt = 1'b1;
        end
      end
      default: begin
        next_st.phase = bsls_pkg::PH_SLEEP;
      end
    endcase

    // After an event the rest of the interval scans or sleeps.
    if (leave_evt) begin
      if (scan_ok) begin
        next_st.phase     = bsls_pkg::PH_SCAN; // R15 R16
        next_st.last_scan = st.now;
        if (st.now - st.last_scan > st.scan_intv) begin
          unique case (st.chan) // R17
            bsls_pkg::CHAN_FIRST: next_st.chan = bsls_pkg::CHAN_MID;
            bsls_pkg::CHAN_MID:   next_st.chan = bsls_pkg::CHAN_LAST;
            default:              next_st.chan = bsls_pkg::CHAN_FIRST;
          endcase
        end
      end else begin
        next_st.phase = bsls_pkg::PH_SLEEP;
      end
    end

    // Link state follows the advertising enable outside a connection.
    unique case (st.link)
      bsls_pkg::LINK_IDLE: begin
        if (st.ctrl[bsls_pkg::CTRL_ADV_EN]) begin
          next_st.link    = bsls_pkg::LINK_ADV;
          next_st.phase   = bsls_pkg::PH_SLEEP;
          next_st.ivl_cnt = '0;
        end
      end
      bsls_pkg::LINK_ADV: begin
        if (!st.ctrl[bsls_pkg::CTRL_ADV_EN]) begin
          next_st.link  = bsls_pkg::LINK_IDLE;
          next_st.phase = bsls_pkg::PH_SLEEP;
          next_st.ctrl[bsls_pkg::CTRL_SCAN_IN_ADV] = 1'b0; // R14
        end
      end
      bsls_pkg::LINK_CONN: begin
      end
      default: begin
        next_st.link = bsls_pkg::LINK_IDLE;
      end
    endcase

    // Register access, answered one cycle after the request.
    if (bus_req) begin
      next_st.wb_ack = 1'b1;
      next_st.wb_dat = 32'h0000_0000;
      if (wb_we_i) begin
        unique case (wb_adr_i)
          bsls_pkg::OFS_CTRL: begin
            next_st.ctrl[bsls_pkg::CTRL_ADV_EN] =
              wval[bsls_pkg::CTRL_ADV_EN];
            // Extensions only stick in the state that owns them.
            next_st.ctrl[bsls_pkg::CTRL_ADV_IN_CONN] =
              wval[bsls_pkg::CTRL_ADV_IN_CONN]
              && st.link == bsls_pkg::LINK_CONN; // R14
            next_st.ctrl[bsls_pkg::CTRL_SCAN_IN_CONN] =
              wval[bsls_pkg::CTRL_SCAN_IN_CONN]
              && st.link == bsls_pkg::LINK_CONN; // R14
            next_st.ctrl[bsls_pkg::CTRL_SCAN_IN_ADV] =
              wval[bsls_pkg::CTRL_SCAN_IN_ADV]
              && st.link == bsls_pkg::LINK_ADV; // R14
          end
          bsls_pkg::OFS_CMD: begin
            if (wval[bsls_pkg::CMD_CONNECT]
                && st.link == bsls_pkg::LINK_ADV) begin
              next_st.link    = bsls_pkg::LINK_CONN;
              next_st.phase   = bsls_pkg::PH_SLEEP;
              next_st.ivl_cnt = '0;
              next_st.ctrl[bsls_pkg::CTRL_SCAN_IN_ADV] = 1'b0;
            end else if (wval[bsls_pkg::CMD_LEAVE]
                         && st.link == bsls_pkg::LINK_CONN) begin
              next_st.link = st.ctrl[bsls_pkg::CTRL_ADV_EN]
                ? bsls_pkg::LINK_ADV : bsls_pkg::LINK_IDLE; // R18
              next_st.phase   = bsls_pkg::PH_SLEEP;
              next_st.ivl_cnt = '0;
              next_st.in_pkt  = 1'b0;
              next_st.widx    = 6'h00;
              next_st.ctrl[bsls_pkg::CTRL_ADV_IN_CONN]  = 1'b0;
              next_st.ctrl[bsls_pkg::CTRL_SCAN_IN_CONN] = 1'b0;
            end
          end
          bsls_pkg::OFS_CONN_INTV:
            next_st.conn_intv = merge(st.conn_intv, wb_dat_i, wb_sel_i);
          bsls_pkg::OFS_LEAD:
            next_st.lead = merge(st.lead, wb_dat_i, wb_sel_i);
          bsls_pkg::OFS_WIN:
            next_st.win = merge(st.win, wb_dat_i, wb_sel_i);
          bsls_pkg::OFS_ADV_INTV:
            next_st.adv_intv = merge(st.adv_intv, wb_dat_i, wb_sel_i);
          bsls_pkg::OFS_ADV_LEN:
            next_st.adv_len = merge(st.adv_len, wb_dat_i, wb_sel_i);
          bsls_pkg::OFS_SCAN_INTV:
            next_st.scan_intv = merge(st.scan_intv, wb_dat_i, wb_sel_i);
          bsls_pkg::OFS_RX_IDX: next_st.ridx = wval[5:0];
          bsls_pkg::OFS_RX_POP: begin
            if (wval[0] && occ != '0) begin
              next_st.rptr = st.rptr + 1'b1; // R08 R19
              next_st.ridx = 6'h00;
            end
          end
          bsls_pkg::OFS_IRQ_CLR: next_st.irq_stat = st.irq_stat & ~wval[3:0];
          bsls_pkg::OFS_IRQ_EN:  next_st.irq_en   = wval[3:0];
          default: begin
          end
        endcase
      end else begin
        unique case (wb_adr_i)
          bsls_pkg::OFS_CTRL:      next_st.wb_dat = {28'h0, st.ctrl};
          // Head entry kind lets software run link commands at once.
          bsls_pkg::OFS_STATUS:    next_st.wb_dat = {13'h0,
            occ != '0 && mem[haddr][1:0] == 2'b11, occ, st.chan, 1'b0,
            st.phase, 2'b00, st.link}; // R09
          bsls_pkg::OFS_CONN_INTV: next_st.wb_dat = st.conn_intv;
          bsls_pkg::OFS_LEAD:      next_st.wb_dat = st.lead;
          bsls_pkg::OFS_WIN:       next_st.wb_dat = st.win;
          bsls_pkg::OFS_ADV_INTV:  next_st.wb_dat = st.adv_intv;
          bsls_pkg::OFS_ADV_LEN:   next_st.wb_dat = st.adv_len;
          bsls_pkg::OFS_SCAN_INTV: next_st.wb_dat = st.scan_intv;
          bsls_pkg::OFS_RX_DATA:   next_st.wb_dat = {24'h0, mem[raddr]};
          bsls_pkg::OFS_RX_IDX:    next_st.wb_dat = {26'h0, st.ridx};
          bsls_pkg::OFS_IRQ_STAT:  next_st.wb_dat = {28'h0, st.irq_stat};
          bsls_pkg::OFS_IRQ_EN:    next_st.wb_dat = {28'h0, st.irq_en};
          default:                 next_st.wb_dat = 32'h0000_0000;
        endcase
      end
    end

    // Hardware events set after the clear, so a same-cycle event wins.
    next_st.irq_stat = next_st.irq_stat | ev; // R12
  end

  ////////////////////////////////////////////////////////////////////////////

  // State register.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= bsls_pkg::STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Packet bytes land in the entry under the write pointer.
  always_ff @(posedge clk_sys) begin
    if (wr_mem) begin
      mem[waddr] <= rx.data; // R07
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Outputs; radio commands come straight from state flops.
  assign wb_dat_o          = st.wb_dat;
  assign wb_ack_o          = st.wb_ack;
  assign irq               = |(st.irq_stat & st.irq_en);
  assign phy.rx_en         = st.phase == bsls_pkg::PH_WORK; // R04
  assign phy.ack_send      = st.ack_send;
  assign phy.ack_withhold  = st.ack_withhold;
  assign phy.adv_active    = st.phase == bsls_pkg::PH_ADV; // R13
  assign phy.scan_active   = st.phase == bsls_pkg::PH_SCAN;
  // Sleep is barred in every phase but sleep, since hardware is busy.
  assign phy.sleep_allow   = st.phase == bsls_pkg::PH_SLEEP; // R06
  assign phy.channel       = st.chan;

endmodule : bsls_sched

// >>> verification/bsls_sched_chk.sv
`timescale 1ns/10ps

// Port-level checks of the scheduler's bus and radio timing.
module bsls_sched_chk (
  // Clock and reset.
  input wire logic                clk_sys,
  input wire logic                rst_b,
  // Bus handshake.
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  // Radio side.
  input wire bsls_pkg::bsls_rx_t  rx,
  input wire bsls_pkg::bsls_phy_t phy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // A packet closes on its last byte in the window; one answer follows.
  sequence s_pkt_end;
    rx.valid && rx.last && phy.rx_en;
  endsequence
  sequence s_answer;
    phy.ack_send ^ phy.ack_withhold;
  endsequence

  ////////////////////////////////////////
  AST_BUS_ANSWER: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered after one cycle");
  AST_BUS_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");
  AST_PKT_ANSWER: assert property (s_pkt_end |=> s_answer)
    else $error("packet end without exactly one answer");
  AST_ANSWER_CAUSE: assert property (
    s_answer |-> $past(rx.valid && rx.last && phy.rx_en))
    else $error("answer without a finished packet");
  AST_WORK_AWAKE: assert property (phy.rx_en |-> !phy.sleep_allow)
    else $error("sleep allowed while receiving");
  // A window is always preceded by the start phase, never by sleep.
  AST_START_FIRST: assert property (
    $rose(phy.rx_en) |-> !$past(phy.sleep_allow))
    else $error("receive window opened straight from sleep");
  AST_ADV_ALONE: assert property (
    phy.adv_active |-> !phy.rx_en && !phy.scan_active)
    else $error("advertising overlaps another activity");
  AST_SCAN_ALONE: assert property (
    phy.scan_active |-> !phy.rx_en && !phy.sleep_allow)
    else $error("scanning overlaps receive or sleep");
  AST_CHAN_STEP: assert property (
    $changed(phy.channel) |-> phy.channel ==
      (($past(phy.channel) == bsls_pkg::CHAN_LAST) ?
       bsls_pkg::CHAN_FIRST : $past(phy.channel) + 6'h01))
    else $error("scan channel skipped or went backwards");
endmodule : bsls_sched_chk

bind bsls_sched bsls_sched_chk bsls_sched_chk_inst (
  .clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx, .phy);

// >>> verification/bsls_master_model.sv
`timescale 1ns/10ps

// Remote master: sends a burst of four-byte packets once the slave listens.
module bsls_master_model (
  // Clock and reset.
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // Burst request from the bench.
  input  wire logic                go,
  input  wire logic [3:0]          pkt_num,
  // Radio link.
  input  wire bsls_pkg::bsls_phy_t phy,
  output      bsls_pkg::bsls_rx_t  rx,
  // Answers counted over the burst.
  output      logic [3:0]          acked,
  output      logic [3:0]          withheld,
  output      logic                done
);
  int k;
  int i;
  int n;

  // Byte zero low bits mark odd packets as control packets.
  initial begin
    rx = '0;
    acked = '0;
    withheld = '0;
    done = 1'b0;
    forever begin
      @(posedge clk_sys);
      done <= 1'b0;
      if (go && !done && rst_b) begin
        acked <= '0;
        withheld <= '0;
        for (n = 0; n < 1000 && !phy.rx_en; n++) @(posedge clk_sys);
        for (k = 0; k < int'(pkt_num); k++) begin
          for (i = 0; i < 4; i++) begin
            rx.valid <= 1'b1;
            rx.data <= (i == 0) ? {k[3:0], 2'b00, {2{k[0]}}}
                                : {k[3:0], i[3:0]};
            rx.last <= (i == 3);
            rx.more_data_flag <= (k < int'(pkt_num) - 1);
            @(posedge clk_sys);
          end
          // Released line shows no stale byte.
          rx.valid <= 1'b0;
          rx.last <= 1'b0;
          rx.data <= ~rx.data;
          @(posedge clk_sys);
          acked <= acked + {3'b000, phy.ack_send};
          withheld <= withheld + {3'b000, phy.ack_withhold};
        end
        done <= 1'b1;
      end
    end
  end
endmodule : bsls_master_model

// >>> verification/testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end

// Self-checking bench for the connection-slave scheduler.
module testbench;
  logic                clk_sys = 1'b0;
  logic                rst_b = 1'b0;
  logic                wb_cyc_i = 1'b0;
  logic                wb_stb_i = 1'b0;
  logic                wb_we_i = 1'b0;
  logic [7:0]          wb_adr_i = 8'h00;
  logic [3:0]          wb_sel_i = 4'hF;
  logic [31:0]         wb_dat_i = 32'h0000_0000;
  logic [31:0]         wb_dat_o;
  logic                wb_ack_o;
  bsls_pkg::bsls_rx_t  rx;
  bsls_pkg::bsls_phy_t phy;
  logic                irq;
  logic                go = 1'b0;
  logic [3:0]          pkt_num = 4'h0;
  logic [3:0]          acked;
  logic [3:0]          withheld;
  logic                done;
  logic [31:0]         rd;
  int                  mismatches = 0;
  int                  check_count = 0;

  bsls_sched bsls_sched_inst (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .rx, .phy, .irq);
  bsls_master_model bsls_master_model_inst (.clk_sys, .rst_b, .go,
    .pkt_num, .phy, .rx, .acked, .withheld, .done);

  always #2 clk_sys = ~clk_sys;

  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // Classic cycle; request held until ack is sampled, read data taken then.
  task automatic wb_cycle(input logic [7:0] adr, input logic we,
                          input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_sys);
    if (n == 20) begin
      mismatches++;
      print_verdict();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_cycle

  // Hands a burst to the master model and waits for it to finish.
  task automatic burst(input logic [3:0] num);
    int n;
    wb_cycle(bsls_pkg::OFS_IRQ_CLR, 1'b1, 32'h0000_000F);
    @(posedge clk_sys);
    pkt_num <= num;
    go <= 1'b1;
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(posedge clk_sys);
    go <= 1'b0;
    if (n == 3000) begin
      mismatches++;
      print_verdict();
    end
  endtask : burst

  task automatic status_occ(input logic [3:0] occ);
    wb_cycle(bsls_pkg::OFS_STATUS, 1'b0, 32'h0000_0000);
    `CHK(rd[17:14], occ)
  endtask : status_occ

  ////////////////////////////////////////
  task automatic reset_and_setup();
    wb_cycle(bsls_pkg::OFS_STATUS, 1'b0, 32'h0000_0000);
    `CHK(rd, 32'h0000_2500)
    `CHK(phy.sleep_allow, 1'b1)
    wb_cycle(8'h3C, 1'b0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // Short intervals keep every event within a few hundred cycles.
    wb_cycle(bsls_pkg::OFS_CONN_INTV, 1'b1, 32'h0000_00C8);
    wb_cycle(bsls_pkg::OFS_LEAD, 1'b1, 32'h0000_000A);
    wb_cycle(bsls_pkg::OFS_WIN, 1'b1, 32'h0000_003C);
    wb_cycle(bsls_pkg::OFS_ADV_INTV, 1'b1, 32'h0000_00C8);
    wb_cycle(bsls_pkg::OFS_ADV_LEN, 1'b1, 32'h0000_0014);
    wb_cycle(bsls_pkg::OFS_SCAN_INTV, 1'b1, 32'h0000_0032);
    wb_cycle(bsls_pkg::OFS_IRQ_EN, 1'b1, 32'h0000_000F);
    wb_cycle(bsls_pkg::OFS_CTRL, 1'b1, 32'h0000_000E);
    wb_cycle(bsls_pkg::OFS_CTRL, 1'b0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
  endtask : reset_and_setup

  task automatic scan_in_adv();
    int n;
    int scans;
    logic mid;
    scans = 0;
    mid = 1'b0;
    wb_cycle(bsls_pkg::OFS_CTRL, 1'b1, 32'h0000_0001);
    wb_cycle(bsls_pkg::OFS_CTRL, 1'b1, 32'h0000_000F);
    wb_cycle(bsls_pkg::OFS_CTRL, 1'b0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0005)
    for (n = 0; n < 700; n++) begin
      @(posedge clk_sys);
      scans += int'(phy.scan_active === 1'b1);
      mid |= (phy.channel === bsls_pkg::CHAN_MID);
    end
    `CHK(scans > 0, 1'b1)
    `CHK(mid, 1'b1)
    wb_cycle(bsls_pkg::OFS_CTRL, 1'b1, 32'h0000_0001);
  endtask : scan_in_adv

  task automatic connect_and_receive();
    int n;
    wb_cycle(bsls_pkg::OFS_CMD, 1'b1, 32'h0000_0001);
    wb_cycle(bsls_pkg::OFS_CTRL, 1'b1, 32'h0000_000F);
    wb_cycle(bsls_pkg::OFS_CTRL, 1'b0, 32'h0000_0000);
    `CHK(rd, 32'h0000_000B)
    burst(4'h3);
    `CHK({acked, withheld}, 8'h30)
    for (n = 0; n < 300 && phy.adv_active !== 1'b1; n++) @(posedge clk_sys);
    `CHK(phy.adv_active, 1'b1)
    for (n = 0; n < 300 && phy.scan_active !== 1'b1; n++) @(posedge clk_sys);
    `CHK(phy.scan_active, 1'b1)
    wb_cycle(bsls_pkg::OFS_IRQ_STAT, 1'b0, 32'h0000_0000);
    `CHK(rd, 32'h0000_000B)
    `CHK(irq, 1'b1)
    status_occ(4'h3);
    wb_cycle(bsls_pkg::OFS_RX_IDX, 1'b1, 32'h0000_0001);
    wb_cycle(bsls_pkg::OFS_RX_DATA, 1'b0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    status_occ(4'h3);
    `CHK(rd[18], 1'b0)
    wb_cycle(bsls_pkg::OFS_RX_POP, 1'b1, 32'h0000_0001);
    status_occ(4'h2);
    `CHK(rd[18], 1'b1)
  endtask : connect_and_receive

  // Six fit beside two waiting entries; the seventh must be refused.
  task automatic overflow();
    int n;
    burst(4'h7);
    `CHK({acked, withheld}, 8'h61)
    status_occ(4'h8);
    wb_cycle(bsls_pkg::OFS_IRQ_EN, 1'b1, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    wb_cycle(bsls_pkg::OFS_IRQ_EN, 1'b1, 32'h0000_0004);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    wb_cycle(bsls_pkg::OFS_IRQ_CLR, 1'b1, 32'h0000_0004);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    for (n = 0; n < 9; n++) begin
      wb_cycle(bsls_pkg::OFS_RX_POP, 1'b1, 32'h0000_0001);
    end
    status_occ(4'h0);
  endtask : overflow

  task automatic leave_states();
    wb_cycle(bsls_pkg::OFS_CMD, 1'b1, 32'h0000_0002);
    wb_cycle(bsls_pkg::OFS_STATUS, 1'b0, 32'h0000_0000);
    `CHK(rd[1:0], 2'h1)
    wb_cycle(bsls_pkg::OFS_CTRL, 1'b0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    wb_cycle(bsls_pkg::OFS_CMD, 1'b1, 32'h0000_0001);
    wb_cycle(bsls_pkg::OFS_CTRL, 1'b1, 32'h0000_0000);
    wb_cycle(bsls_pkg::OFS_CMD, 1'b1, 32'h0000_0002);
    wb_cycle(bsls_pkg::OFS_STATUS, 1'b0, 32'h0000_0000);
    `CHK(rd[1:0], 2'h0)
  endtask : leave_states

  ////////////////////////////////////////
  // Main sequence; reset is released on a sampling edge, by a nonblocking write.
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    reset_and_setup();
    scan_in_adv();
    connect_and_receive();
    overflow();
    leave_states();
    print_verdict();
  end
endmodule : testbench
